// ### sat_supply_diag_status.sv
// two-wire target serving the read-only diagnostic status bytes
`timescale 1ns/100ps
`default_nettype none
module sat_supply_diag_status (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_drive,
    output logic sda_oe,
    input wire logic addr_sel,
    input wire logic overload,
    input wire logic temp_above_shdn,
    input wire logic temp_below_release,
    input wire logic supply_low
);
    import diag_status_pkg::*;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic adr_s1;
        logic adr_s2;
        logic ovl_s1;
        logic ovl_s2;
        logic hot_s1;
        logic hot_s2;
        logic cool_s1;
        logic cool_s2;
        logic low_s1;
        logic low_s2;
        logic overload_flag;
        logic overtemp_flag;
        logic low_supply_flag;
        state_t fsm;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic rw;
        logic oe;
    } regs_t;

    regs_t r_q;
    regs_t r_d;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [6:0] my_addr;
    logic [7:0] primary_byte;

    // edges are judged on the settled stages only; a glitch on sda that is sampled while scl is high still reads as a start
    assign scl_rise = r_q.scl_s2 & ~r_q.scl_s3;
    assign scl_fall = r_q.scl_s3 & ~r_q.scl_s2;
    assign start_det = r_q.scl_s2 & r_q.scl_s3 & r_q.sda_s3 & ~r_q.sda_s2;
    assign stop_det = r_q.scl_s2 & r_q.scl_s3 & ~r_q.sda_s3 & r_q.sda_s2;
    assign my_addr = {TARGET_ADDR_BASE, r_q.adr_s2};

    always_comb begin
        primary_byte = STATUS_RESET;
        primary_byte[OVERLOAD_BIT] = r_q.overload_flag;
        primary_byte[OVERTEMP_BIT] = r_q.overtemp_flag;
        primary_byte[LOW_SUPPLY_BIT] = r_q.low_supply_flag;
    end

    function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [7:0] prim);
        logic [7:0] v;
        v = STATUS_RESET;
        if (addr == ADDR_PRIMARY) begin
            v = prim;
        end
        return v;
    endfunction : read_byte

    always_comb begin
        r_d = r_q;
        r_d.scl_s1 = scl_pin;
        r_d.scl_s2 = r_q.scl_s1;
        r_d.scl_s3 = r_q.scl_s2;
        r_d.sda_s1 = sda_pin;
        r_d.sda_s2 = r_q.sda_s1;
        r_d.sda_s3 = r_q.sda_s2;
        r_d.adr_s1 = addr_sel;
        r_d.adr_s2 = r_q.adr_s1;
        r_d.ovl_s1 = overload;
        r_d.ovl_s2 = r_q.ovl_s1;
        r_d.hot_s1 = temp_above_shdn;
        r_d.hot_s2 = r_q.hot_s1;
        r_d.cool_s1 = temp_below_release;
        r_d.cool_s2 = r_q.cool_s1;
        r_d.low_s1 = supply_low;
        r_d.low_s2 = r_q.low_s1;
        // flags follow their comparators; bus traffic never touches them
        r_d.overload_flag = r_q.ovl_s2;
        r_d.low_supply_flag = r_q.low_s2;
        if (r_q.hot_s2) begin
            r_d.overtemp_flag = 1'b1;
        end else if (r_q.cool_s2) begin
            r_d.overtemp_flag = 1'b0;
        end
        if (start_det) begin
            r_d.fsm = S_ADDR;
            r_d.bitcnt = '0;
            r_d.oe = 1'b0;
        end else if (stop_det) begin
            r_d.fsm = S_IDLE;
            r_d.oe = 1'b0;
        end else begin
            unique case (r_q.fsm)
                S_IDLE, S_IGNORE: begin
                    r_d.oe = 1'b0;
                end
                S_ADDR, S_PTR: begin
                    if (scl_rise) begin
                        r_d.shreg = {r_q.shreg[6:0], r_q.sda_s2};
                        r_d.bitcnt = r_q.bitcnt + 4'h1;
                    end else if (scl_fall && r_q.bitcnt == BITS_PER_BYTE) begin
                        if (r_q.fsm == S_PTR) begin
                            r_d.ptr = r_q.shreg;
                            r_d.oe = 1'b1;
                            r_d.fsm = S_PTR_ACK;
                        end else if (r_q.shreg[7:1] == my_addr) begin
                            r_d.oe = 1'b1;
                            r_d.rw = r_q.shreg[0];
                            r_d.fsm = S_ADDR_ACK;
                        end else begin
                            r_d.fsm = S_IGNORE;
                        end
                    end
                end
                S_ADDR_ACK: begin
                    if (scl_fall) begin
                        r_d.bitcnt = '0;
                        if (r_q.rw) begin
                            r_d.shreg = read_byte(r_q.ptr, primary_byte);
                            r_d.oe = ~r_d.shreg[7];
                            r_d.fsm = S_TX;
                        end else begin
                            r_d.oe = 1'b0;
                            r_d.fsm = S_PTR;
                        end
                    end
                end
                S_PTR_ACK: begin
                    // the bytes are read only, so any data byte after the pointer is refused
                    if (scl_fall) begin
                        r_d.oe = 1'b0;
                        r_d.fsm = S_IGNORE;
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        r_d.bitcnt = r_q.bitcnt + 4'h1;
                        if (r_q.bitcnt == LAST_TX_BIT) begin
                            r_d.oe = 1'b0;
                            r_d.ptr = r_q.ptr + 8'h01;
                            r_d.fsm = S_TX_ACK;
                        end else begin
                            r_d.shreg = {r_q.shreg[6:0], 1'b0};
                            r_d.oe = ~r_q.shreg[6];
                        end
                    end
                end
                S_TX_ACK: begin
                    if (scl_rise && r_q.sda_s2) begin
                        r_d.fsm = S_IGNORE;
                    end else if (scl_fall) begin
                        r_d.bitcnt = '0;
                        r_d.shreg = read_byte(r_q.ptr, primary_byte);
                        r_d.oe = ~r_d.shreg[7];
                        r_d.fsm = S_TX;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_q <= '0;
            // bus stages start at the idle high level so leaving reset makes no false edge
            r_q.scl_s1 <= 1'b1;
            r_q.scl_s2 <= 1'b1;
            r_q.scl_s3 <= 1'b1;
            r_q.sda_s1 <= 1'b1;
            r_q.sda_s2 <= 1'b1;
            r_q.sda_s3 <= 1'b1;
            r_q.fsm <= S_IDLE;
            r_q.ptr <= ADDR_PRIMARY;
        end else begin
            r_q <= r_d;
        end
    end

    // open-drain: only ever pull low
    assign sda_drive = 1'b0;
    assign sda_oe = r_q.oe;

    sequence s_addr_byte_done;
        r_q.fsm == S_ADDR && scl_fall && r_q.bitcnt == BITS_PER_BYTE && !start_det && !stop_det;
    endsequence

    sequence s_read_load;
        r_q.fsm == S_ADDR_ACK && scl_fall && r_q.rw && !start_det && !stop_det;
    endsequence

    property p_addr_ack;
        @(posedge ref_clk) disable iff (!rst_b)
        s_addr_byte_done ##0 (r_q.shreg[7:1] == my_addr) |=> sda_oe && r_q.fsm == S_ADDR_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

    property p_addr_other;
        @(posedge ref_clk) disable iff (!rst_b)
        s_addr_byte_done ##0 (r_q.shreg[7:1] != my_addr) |=> !sda_oe && r_q.fsm == S_IGNORE;
    endproperty
    a_addr_other: assert property (p_addr_other) else $error("foreign address answered");

    property p_no_write;
        @(posedge ref_clk) disable iff (!rst_b)
        r_q.fsm == S_PTR_ACK && scl_fall && !start_det && !stop_det
            |=> !sda_oe && r_q.fsm == S_IGNORE;
    endproperty
    a_no_write: assert property (p_no_write) else $error("data write accepted");

    property p_overload;
        @(posedge ref_clk) disable iff (!rst_b)
        overload [*3] |=> r_q.overload_flag ##1 primary_byte[OVERLOAD_BIT];
    endproperty
    a_overload: assert property (p_overload) else $error("overload not reported");

    property p_overtemp_set;
        @(posedge ref_clk) disable iff (!rst_b)
        temp_above_shdn [*3] |=> r_q.overtemp_flag;
    endproperty
    a_overtemp_set: assert property (p_overtemp_set) else $error("overtemperature missed");

    property p_overtemp_clear;
        @(posedge ref_clk) disable iff (!rst_b)
        $fell(r_q.overtemp_flag) |-> $past(r_q.cool_s2) && !$past(r_q.hot_s2);
    endproperty
    a_overtemp_clear: assert property (p_overtemp_clear) else $error("overtemp cleared early");

    property p_low_supply;
        @(posedge ref_clk) disable iff (!rst_b)
        !supply_low [*3] |=> !r_q.low_supply_flag && !primary_byte[LOW_SUPPLY_BIT];
    endproperty
    a_low_supply: assert property (p_low_supply) else $error("low supply stuck");

    property p_reserved;
        @(posedge ref_clk) disable iff (!rst_b)
        s_read_load |=> r_q.shreg[5:1] == 5'h00 && (r_q.ptr == ADDR_PRIMARY || r_q.shreg == 8'h00);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit read as one");

    property p_reset_clear;
        @(posedge ref_clk) disable iff (!rst_b)
        !$past(rst_b) |-> primary_byte == STATUS_RESET && !sda_oe;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("status not zero after reset");

endmodule : sat_supply_diag_status
`default_nettype wire

// ### diag_status_pkg.sv
// constants and types for the supply diagnostic status target
// Operation
// - status bytes at addresses 0 and 1 are read only; host never writes them
// - bit 0 of primary status is 1 while output overload is present
// - bit 6 sets above 150 degrees, clears only once below 135 degrees
// - bit 7 of primary status is 1 while input supply is low
// - secondary status byte and primary bits 1 to 5 are reserved
// - every status bit is zero after power-on
// - target address 0001000 with pin low, 0001001 with pin high
`default_nettype none
package diag_status_pkg;
    localparam logic [7:0] ADDR_PRIMARY = 8'h00;
    localparam logic [7:0] ADDR_SECONDARY = 8'h01;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int OVERLOAD_BIT = 0;
    localparam int OVERTEMP_BIT = 6;
    localparam int LOW_SUPPLY_BIT = 7;
    localparam logic [5:0] TARGET_ADDR_BASE = 6'h04;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_PTR,
        S_PTR_ACK,
        S_TX,
        S_TX_ACK,
        S_IGNORE
    } state_t;
endpackage : diag_status_pkg
`default_nettype wire

// ### sat_bus_master.sv
// two-wire bus master model standing in for the receiver host
`timescale 1ns/100ps
`default_nettype none
module sat_bus_master (
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ten cycle half period stays well above the delay of the target's three stage scl and sda synchronizers
    task automatic half;
        repeat (10) @(negedge ref_clk);
    endtask : half
    task automatic start;
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
        half();
    endtask : start
    task automatic stop;
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask : stop
    // msb first, ninth bit is the acknowledge; released line reads high via pull-up
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                        output logic ack);
        logic [8:0] sh;
        sh = {d, ai};
        for (int i = 8; i >= 0; i--) begin
            sda_low = ~sh[i];
            half();
            scl = 1'b1;
            repeat (5) @(negedge ref_clk);
            sh[i] = sda;
            repeat (5) @(negedge ref_clk);
            scl = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
        q = sh[8:1];
        ack = sh[0];
    endtask : xfer
endmodule : sat_bus_master
`default_nettype wire

// ### sat_supply_diag_status_tb.sv
// self-checking bench for the diagnostic status target
`timescale 1ns/100ps
`default_nettype none
module sat_supply_diag_status_tb;
    import diag_status_pkg::*;
    logic ref_clk, rst_b, scl, sda_low, sda_oe, sda_o, sel, ovl, hot, cool, low, ot;
    logic sda;
    logic [7:0] q;
    logic ack;
    int n_errors, checked;
    int t_tab[4] = '{2, 1, 0, 1};
    assign sda = !((sda_oe && !sda_o) || sda_low);
    sat_supply_diag_status sat_supply_diag_status_inst (.ref_clk(ref_clk), .rst_b(rst_b),
        .scl_pin(scl), .sda_pin(sda), .sda_drive(sda_o), .sda_oe(sda_oe), .addr_sel(sel),
        .overload(ovl), .temp_above_shdn(hot), .temp_below_release(cool),
        .supply_low(low));
    sat_bus_master m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    function automatic logic [7:0] dev(input logic s, input logic rd);
        return {7'b0001000 | {6'h00, s}, rd};
    endfunction : dev
    function automatic logic [7:0] exp_byte(input int p);
        return (p == 0) ? {low, ot, 5'h00, ovl} : 8'h00;
    endfunction : exp_byte
    // t: 2 above shutdown, 1 inside the hysteresis band, 0 below release
    task automatic apply(input int t);
        @(negedge ref_clk);
        ovl = 1'($urandom_range(1));
        low = 1'($urandom_range(1));
        sel = 1'($urandom_range(1));
        hot = (t == 2);
        cool = (t == 0);
        if (t != 1) ot = (t == 2);
        repeat (6) @(negedge ref_clk);
    endtask : apply
    task automatic read_regs(input logic [7:0] p, input int n);
        m.start();
        m.xfer(dev(sel, 1'b0), 1'b1, q, ack);
        check({7'h0, ack}, 8'h00);
        m.xfer(p, 1'b1, q, ack);
        check({7'h0, ack}, 8'h00);
        m.start();
        m.xfer(dev(sel, 1'b1), 1'b1, q, ack);
        check({7'h0, ack}, 8'h00);
        for (int i = 0; i < n; i++) begin
            m.xfer(8'hff, i == n - 1, q, ack);
            check(q, exp_byte(int'(p) + i));
        end
        m.stop();
    endtask : read_regs
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        rst_b = 1'b0;
        {sel, ovl, hot, cool, low, ot} = '0;
        n_errors = 0;
        checked = 0;
        void'($urandom(32'h2bb7));
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        read_regs(8'h00, 3);
        // band corners first so the held overtemp value is exercised both ways
        for (int k = 0; k < 10; k++) begin
            apply(k < 4 ? t_tab[k] : $urandom_range(2));
            read_regs(k[0] ? 8'h01 : 8'h00, 2 + k % 2);
            read_regs(8'h00, 1);
        end
        m.start();
        m.xfer(dev(~sel, 1'b0), 1'b1, q, ack);
        m.stop();
        check({7'h0, ack}, 8'h01);
        m.start();
        m.xfer(dev(sel, 1'b0), 1'b1, q, ack);
        m.xfer(8'h00, 1'b1, q, ack);
        m.xfer(8'hc1, 1'b1, q, ack);
        m.stop();
        check({7'h0, ack}, 8'h01);
        read_regs(8'h00, 2);
        end_of_test();
    end
endmodule : sat_supply_diag_status_tb
`default_nettype wire
